// ==== hw/motor_restart_speed_search.sv ====
`default_nettype none
// How it works
// - after run, inject DC until output frequency reaches the start braking point
// - DC voltage ramps upward at programmable rate, 0.01 to 300.00 percent
// - power-loss restart selector: 0 off, 1 from command, 2 from minimum
// - resume if supply loss shorter than limit, else switch output off
// - ride-through active only in undervoltage indicated state
// - after supply loss hold output off for base-block interval
// - same base-block wait after external block and after fault reset
// - speed search only while current exceeds threshold, else normal ramp
// - during search voltage follows the volts-per-hertz curve
// - command-frequency search decelerates with its own programmable time
// - auto deceleration suppressed while searching
// - restart after current, ground or voltage trip, search from maximum frequency
// - budget drops one per fault, restored after 10 minutes fault-free
// - search type 0 off, 1 command, 2 fwd, 3 rev, 4 fwd-rev, 5 rev-fwd
// - types 2 and 4 start from the forward search frequency, types 3 and 5 from the reverse one
// - ramp pauses at gap frequency for dwell time on accel and decel
module motor_restart_speed_search #(
	parameter int unsigned TICK_CYCLES = restart_pkg::TICK_CYCLES,
	parameter int unsigned RETRY_WINDOW_TICKS = restart_pkg::RETRY_WINDOW_TICKS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run_req,
	input wire logic [15:0] freq_cmd,
	input wire logic [15:0] freq_min,
	input wire logic [15:0] freq_max,
	input wire logic [15:0] dcb_start_freq,
	input wire logic [15:0] dc_ramp_rate,
	input wire logic [1:0] pwr_restart_sel,
	input wire logic [15:0] loss_limit,
	input wire logic [15:0] block_time,
	input wire logic [7:0] search_cur_level,
	input wire logic [7:0] out_current_pct,
	input wire logic [15:0] search_dec_step,
	input wire logic [15:0] accel_step,
	input wire logic [3:0] retry_count_cfg,
	input wire logic [2:0] search_type,
	input wire logic [15:0] search_freq_fwd,
	input wire logic [15:0] search_freq_rev,
	input wire logic [15:0] gap_acc_time,
	input wire logic [15:0] gap_acc_freq,
	input wire logic [15:0] gap_dec_time,
	input wire logic [15:0] gap_dec_freq,
	input wire logic [15:0] vf_volts_per_hz,
	input wire logic undervoltage_indication,
	input wire logic ext_block,
	input wire logic fault_reset,
	input wire logic excess_current_trip,
	input wire logic excess_voltage_trip,
	input wire logic ground_leak_trip,
	output logic output_on,
	output logic dc_inject,
	output logic [16:0] dc_level,
	output logic [15:0] out_freq,
	output logic [31:0] out_volt,
	output logic reverse,
	output logic searching,
	output logic auto_dec_inhibit,
	output logic [3:0] retry_left,
	output logic tripped_off
);
	// ==============================
	// tick and state
	// ==============================
	logic [24:0] pre_r;
	logic tick_r;
	restart_pkg::seq_state_t st_r, st_nxt;
	logic [3:0] retry_r;
	logic off_r, rev_r, dcb_r, on_r, ss_r, inh_r;
	logic [16:0] dcl_r;
	logic [31:0] volt_r;
	logic [15:0] fr_r;
	logic [15:0] freq;
	logic [15:0] prev_freq_r;
	logic [15:0] target;
	logic [15:0] step;
	logic load;
	logic [15:0] load_val;
	logic hold;
	logic trip_any;
	logic search_ok;
	logic loss_done, block_done, dwell_done, window_done;
	logic dwell_hit_acc, dwell_hit_dec;
	logic [3:0] retry_cfg_lim;
	logic [15:0] dwell_time_r;
	logic [15:0] search_start;
	logic retry_trip;
	logic block_req;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_r <= '0;
			tick_r <= 1'b0;
		end else if (ce) begin
			tick_r <= (pre_r == 25'(TICK_CYCLES - 1));
			pre_r <= (pre_r == 25'(TICK_CYCLES - 1)) ? '0 : pre_r + 1'b1;
		end
	end

	// ==============================
	// decode
	// ==============================
	assign trip_any = excess_current_trip | excess_voltage_trip | ground_leak_trip;
	assign retry_trip = trip_any && (retry_r != 4'h0) && (st_r != restart_pkg::ST_IDLE);
	assign block_req = ext_block | fault_reset;
	// settings above ten are clamped, so a bad setting cannot inflate the budget
	assign retry_cfg_lim = (retry_count_cfg > restart_pkg::RETRY_MAX) ? restart_pkg::RETRY_MAX
		: retry_count_cfg;
	assign search_ok = (search_type != restart_pkg::SS_OFF)
		&& (out_current_pct > search_cur_level);
	// forward-first modes start at the forward point, reverse ones at reverse
	assign search_start = (search_type == restart_pkg::SS_REV
		|| search_type == restart_pkg::SS_REV_FWD) ? search_freq_rev
		: (search_type == restart_pkg::SS_CMD) ? freq_cmd : search_freq_fwd;
	// a zero dwell time never arms the pause
	assign dwell_hit_acc = (gap_acc_time != 16'h0000) && prev_freq_r < gap_acc_freq
		&& freq >= gap_acc_freq;
	assign dwell_hit_dec = (gap_dec_time != 16'h0000) && prev_freq_r > gap_dec_freq
		&& freq <= gap_dec_freq;

	// ==============================
	// timers
	// ==============================
	tick_timer #(.W(16)) u_loss (.clk(clk), .rst(rst), .ce(ce), .tick(tick_r),
		.run(st_r == restart_pkg::ST_LOSS), .limit(loss_limit), .done(loss_done));
	tick_timer #(.W(16)) u_block (.clk(clk), .rst(rst), .ce(ce), .tick(tick_r),
		.run(st_r == restart_pkg::ST_BLOCK), .limit(block_time), .done(block_done));
	tick_timer #(.W(16)) u_dwell (.clk(clk), .rst(rst), .ce(ce), .tick(tick_r),
		.run(st_r == restart_pkg::ST_DWELL), .limit(dwell_time_r), .done(dwell_done));
	tick_timer #(.W(20)) u_win (.clk(clk), .rst(rst), .ce(ce), .tick(tick_r),
		.run(retry_r != retry_cfg_lim && !trip_any),
		.limit(20'(RETRY_WINDOW_TICKS)), .done(window_done));

	// ==============================
	// ramp control
	// ==============================
	always_comb begin
		target = freq_cmd;
		step = accel_step;
		load = 1'b0;
		load_val = 16'h0000;
		hold = 1'b0;
		case (st_r)
			restart_pkg::ST_IDLE: begin
				target = 16'h0000;
				load = 1'b1; // output is off, so a new start begins from standstill
			end
			restart_pkg::ST_DCB: begin
				target = dcb_start_freq;
			end
			restart_pkg::ST_SEARCH: begin
				step = search_dec_step;
				target = freq_min;
			end
			restart_pkg::ST_LOSS, restart_pkg::ST_BLOCK, restart_pkg::ST_DWELL: begin
				hold = 1'b1;
			end
			default: begin
			end
		endcase
		if (st_r == restart_pkg::ST_BLOCK && block_done) begin
			load = 1'b1;
			if (retry_r != retry_cfg_lim && search_ok)
				load_val = freq_max;
			else if (pwr_restart_sel == restart_pkg::PWR_RESTART_MIN)
				load_val = freq_min;
			else if (search_ok)
				load_val = search_start;
			else
				load_val = freq_min;
		end
	end

	freq_ramp u_ramp (.clk(clk), .rst(rst), .ce(ce), .tick(tick_r), .load(load),
		.load_val(load_val), .hold(hold), .target(target), .step(step), .freq(freq));

	// ==============================
	// sequencer
	// ==============================
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			restart_pkg::ST_IDLE:
				if (run_req && !off_r)
					st_nxt = restart_pkg::ST_DCB;
			restart_pkg::ST_DCB:
				if (!run_req)
					st_nxt = restart_pkg::ST_IDLE;
				else if (freq >= dcb_start_freq)
					st_nxt = restart_pkg::ST_RUN;
			restart_pkg::ST_RUN, restart_pkg::ST_DWELL, restart_pkg::ST_SEARCH: begin
				if (st_r == restart_pkg::ST_DWELL && dwell_done)
					st_nxt = restart_pkg::ST_RUN;
				else if (st_r == restart_pkg::ST_SEARCH && (freq <= freq_min || !search_ok))
					st_nxt = restart_pkg::ST_RUN;
				else if (st_r == restart_pkg::ST_RUN && (dwell_hit_acc || dwell_hit_dec))
					st_nxt = restart_pkg::ST_DWELL;
				if (!run_req)
					st_nxt = restart_pkg::ST_IDLE;
				else if (undervoltage_indication
					&& pwr_restart_sel != restart_pkg::PWR_RESTART_OFF)
					st_nxt = restart_pkg::ST_LOSS;
				else if (retry_trip || block_req)
					st_nxt = restart_pkg::ST_BLOCK;
				else if (trip_any)
					st_nxt = restart_pkg::ST_IDLE;
			end
			restart_pkg::ST_LOSS:
				if (loss_done)
					st_nxt = restart_pkg::ST_IDLE;
				else if (!undervoltage_indication)
					st_nxt = restart_pkg::ST_BLOCK;
			restart_pkg::ST_BLOCK:
				if (!run_req)
					st_nxt = restart_pkg::ST_IDLE;
				else if (block_done && !block_req)
					st_nxt = (search_ok) ? restart_pkg::ST_SEARCH
						: restart_pkg::ST_RUN;
			default:
				st_nxt = restart_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= restart_pkg::ST_IDLE;
			off_r <= 1'b0;
			prev_freq_r <= 16'h0000;
			dwell_time_r <= 16'h0000;
		end else if (ce) begin
			st_r <= st_nxt;
			prev_freq_r <= freq;
			// latched until the run request drops, so a stopped drive never restarts itself
			if (st_nxt == restart_pkg::ST_IDLE && st_r != restart_pkg::ST_IDLE
				&& run_req)
				off_r <= 1'b1;
			else if (!run_req)
				off_r <= 1'b0;
			if (dwell_hit_acc)
				dwell_time_r <= gap_acc_time;
			else if (dwell_hit_dec)
				dwell_time_r <= gap_dec_time;
		end
	end

	// ==============================
	// retry budget
	// ==============================
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			retry_r <= 4'h0;
		else if (ce) begin
			if (st_r == restart_pkg::ST_IDLE && !run_req)
				retry_r <= retry_cfg_lim;
			else if (retry_trip && (st_r == restart_pkg::ST_RUN || st_r ==
				restart_pkg::ST_SEARCH || st_r == restart_pkg::ST_DWELL))
				retry_r <= retry_r - 1'b1;
			else if (window_done)
				retry_r <= retry_cfg_lim;
		end
	end

	// ==============================
	// outputs
	// ==============================
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			on_r <= 1'b0;
			dcb_r <= 1'b0;
			dcl_r <= '0;
			volt_r <= '0;
			fr_r <= 16'h0000;
			rev_r <= 1'b0;
			ss_r <= 1'b0;
			inh_r <= 1'b0;
		end else if (ce) begin
			on_r <= (st_r == restart_pkg::ST_DCB || st_r == restart_pkg::ST_RUN
				|| st_r == restart_pkg::ST_SEARCH || st_r == restart_pkg::ST_DWELL);
			dcb_r <= (st_r == restart_pkg::ST_DCB);
			if (st_r != restart_pkg::ST_DCB)
				dcl_r <= '0;
			else if (tick_r && dcl_r < 17'h186a0)
				dcl_r <= dcl_r + {1'b0, dc_ramp_rate};
			volt_r <= freq * vf_volts_per_hz;
			fr_r <= freq;
			rev_r <= (search_type == restart_pkg::SS_REV
				|| search_type == restart_pkg::SS_REV_FWD);
			ss_r <= (st_r == restart_pkg::ST_SEARCH);
			inh_r <= (st_r == restart_pkg::ST_SEARCH);
		end
	end

	assign output_on = on_r;
	assign dc_inject = dcb_r;
	assign dc_level = dcl_r;
	assign out_freq = fr_r;
	assign out_volt = volt_r;
	assign reverse = rev_r;
	assign searching = ss_r;
	assign auto_dec_inhibit = inh_r;
	assign retry_left = retry_r;
	assign tripped_off = off_r;

	// ==============================
	// checks
	// ==============================
	a_dc_until_point: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_DCB && run_req && freq < dcb_start_freq
		|=> st_r == restart_pkg::ST_DCB) else $error("dc injection ended early");
	a_loss_turns_off: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_LOSS && loss_done
		|=> st_r == restart_pkg::ST_IDLE && off_r) else $error("long loss kept output");
	a_loss_needs_uv: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_RUN && !undervoltage_indication && run_req
		|=> st_r != restart_pkg::ST_LOSS) else $error("ride-through without undervoltage");
	a_block_holds_off: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_BLOCK ##1 ce && st_r == restart_pkg::ST_BLOCK
		|-> !output_on) else $error("output on during base block");
	a_search_needs_cur: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_BLOCK && st_nxt == restart_pkg::ST_SEARCH
		|-> out_current_pct > search_cur_level) else $error("search below current");
	a_inhibit_search: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_SEARCH |=> auto_dec_inhibit)
		else $error("auto decel not inhibited");
	a_retry_step: assert property (@(posedge clk) disable iff (rst)
		ce && retry_trip && st_r == restart_pkg::ST_RUN && !(!run_req)
		|=> retry_r == $past(retry_r) - 4'h1) else $error("retry budget not decremented");
	a_zero_dwell: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_RUN && gap_acc_time == 16'h0000
		&& gap_dec_time == 16'h0000 |=> st_r != restart_pkg::ST_DWELL)
		else $error("dwell with zero time");
	a_off_latched: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_IDLE && off_r && run_req
		|=> st_r == restart_pkg::ST_IDLE) else $error("restart after switch-off");
	a_search_low_cur: assert property (@(posedge clk) disable iff (rst)
		ce && st_r == restart_pkg::ST_SEARCH && !search_ok && run_req
		&& !undervoltage_indication && !trip_any && !block_req
		|=> st_r == restart_pkg::ST_RUN) else $error("search kept below current");
endmodule : motor_restart_speed_search
`default_nettype wire

// ==== common/restart_pkg.sv ====
`default_nettype none
package restart_pkg;
	// frequencies in 0.01 Hz, times in 0.01 s ticks unless noted
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned TICK_MS = 10;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam logic [15:0] DC_RAMP_RATE_RST = 16'h1388; // 50.00 %
	localparam logic [15:0] DC_RAMP_RATE_MIN = 16'h0001;
	localparam logic [15:0] DC_RAMP_RATE_MAX = 16'h7530;
	localparam logic [1:0] PWR_RESTART_RST = 2'h0;
	localparam logic [1:0] PWR_RESTART_OFF = 2'h0;
	localparam logic [1:0] PWR_RESTART_CMD = 2'h1;
	localparam logic [1:0] PWR_RESTART_MIN = 2'h2;
	localparam logic [15:0] LOSS_LIMIT_RST = 16'h00c8; // 2.0 s
	localparam logic [15:0] BLOCK_TIME_RST = 16'h0032; // 0.5 s
	localparam logic [15:0] TIME_01S_MIN = 16'h000a;
	localparam logic [15:0] TIME_50S_MAX = 16'h01f4;
	localparam logic [7:0] SEARCH_CUR_RST = 8'h78; // 120 %
	localparam logic [15:0] SEARCH_DEC_RST = 16'h012c; // 3.00 s
	localparam logic [3:0] RETRY_MAX = 4'ha;
	localparam int unsigned RETRY_WINDOW_TICKS = 60000; // 10 minutes
	localparam logic [15:0] GAP_FREQ_RST = 16'h0258; // 6.00 Hz
	localparam logic [2:0] SS_OFF = 3'h0;
	localparam logic [2:0] SS_CMD = 3'h1;
	localparam logic [2:0] SS_FWD = 3'h2;
	localparam logic [2:0] SS_REV = 3'h3;
	localparam logic [2:0] SS_FWD_REV = 3'h4;
	localparam logic [2:0] SS_REV_FWD = 3'h5;
	typedef enum logic [2:0] {ST_IDLE, ST_DCB, ST_RUN, ST_LOSS, ST_BLOCK, ST_SEARCH, ST_DWELL}
		seq_state_t;
endpackage : restart_pkg
`default_nettype wire

// ==== hw/tick_timer.sv ====
`default_nettype none
// counts ticks of 10 ms while run is high; done when count reaches limit
module tick_timer #(
	parameter int unsigned W = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic run,
	input wire logic [W-1:0] limit,
	output logic done
);
	logic [W-1:0] cnt_r;
	assign done = run && (cnt_r >= limit);
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_r <= '0;
		else if (ce) begin
			if (!run)
				cnt_r <= '0;
			else if (tick && !done)
				cnt_r <= cnt_r + 1'b1;
		end
	end
endmodule : tick_timer
`default_nettype wire

// ==== hw/freq_ramp.sv ====
`default_nettype none
// output frequency ramp: steps toward target by step each tick, holds when hold
module freq_ramp (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic load,
	input wire logic [15:0] load_val,
	input wire logic hold,
	input wire logic [15:0] target,
	input wire logic [15:0] step,
	output logic [15:0] freq
);
	logic [15:0] freq_r;
	logic [16:0] up;
	logic [15:0] dn;
	assign freq = freq_r;
	assign up = {1'b0, freq_r} + {1'b0, step};
	assign dn = (freq_r > step) ? freq_r - step : 16'h0000;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			freq_r <= 16'h0000;
		else if (ce) begin
			if (load)
				freq_r <= load_val;
			else if (tick && !hold) begin
				if (freq_r < target)
					freq_r <= (up[15:0] > target || up[16]) ? target : up[15:0];
				else if (freq_r > target)
					freq_r <= (dn < target) ? target : dn;
			end
		end
	end
endmodule : freq_ramp
`default_nettype wire

// ==== sim/motor_model.sv ====
`default_nettype none
// ========================================
// coasting load seen through the output stage
module motor_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic output_on,
	input wire logic spinning,
	output logic [7:0] out_current_pct
);
	timeunit 1ns;
	timeprecision 1ns;
	// a spinning load shows high current even while blocked, so the block-end decision sees it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_current_pct <= 8'h00;
		end else begin
			out_current_pct <= spinning ? 8'hc8 : (output_on ? 8'h32 : 8'h00);
		end
	end
endmodule : motor_model
`default_nettype wire

// ==== sim/motor_restart_speed_search_tb.sv ====
`default_nettype none
module motor_restart_speed_search_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ========================================
	// stimulus and observed signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic run_req = 1'b0;
	logic spinning = 1'b0;
	logic undervoltage_indication = 1'b0;
	logic ext_block = 1'b0, fault_reset = 1'b0;
	logic excess_current_trip = 1'b0, excess_voltage_trip = 1'b0, ground_leak_trip = 1'b0;
	logic [1:0] pwr_restart_sel = 2'h0;
	logic [2:0] search_type = 3'h0;
	logic [3:0] retry_count_cfg = 4'h2;
	logic [7:0] search_cur_level = 8'h78;
	logic [15:0] freq_cmd = 16'h0bb8, freq_min = 16'h00c8, freq_max = 16'h1770;
	logic [15:0] dcb_start_freq = 16'h01f4; // braking point kept below 25 Hz
	logic [15:0] dc_ramp_rate = 16'h1388, loss_limit = 16'h0014, block_time = 16'h000a;
	logic [15:0] search_dec_step = 16'h0064, accel_step = 16'h0064;
	logic [15:0] search_freq_fwd = 16'h1388, search_freq_rev = 16'h1194;
	logic [15:0] gap_acc_time = 16'h0000, gap_dec_time = 16'h0000;
	logic [15:0] gap_acc_freq = 16'h0258, gap_dec_freq = 16'h0258, vf_volts_per_hz = 16'h0004;
	logic [7:0] out_current_pct;
	logic output_on, dc_inject, reverse, searching, auto_dec_inhibit, tripped_off;
	logic [16:0] dc_level, lvl0;
	logic [15:0] out_freq, f0;
	logic [31:0] out_volt;
	logic [3:0] retry_left;
	logic ok;
	int n_fail = 0;
	int n_checks = 0;
	int cycles = 0;

	always #20 clk = ~clk;

	motor_restart_speed_search #(.TICK_CYCLES(10), .RETRY_WINDOW_TICKS(50)) dut (
		.clk, .rst, .ce, .run_req, .freq_cmd, .freq_min, .freq_max, .dcb_start_freq,
		.dc_ramp_rate, .pwr_restart_sel, .loss_limit, .block_time, .search_cur_level,
		.out_current_pct, .search_dec_step, .accel_step, .retry_count_cfg, .search_type,
		.search_freq_fwd, .search_freq_rev, .gap_acc_time, .gap_acc_freq, .gap_dec_time,
		.gap_dec_freq, .vf_volts_per_hz, .undervoltage_indication, .ext_block, .fault_reset,
		.excess_current_trip, .excess_voltage_trip, .ground_leak_trip, .output_on, .dc_inject,
		.dc_level, .out_freq, .out_volt, .reverse, .searching, .auto_dec_inhibit, .retry_left,
		.tripped_off
	);

	motor_model motor (.clk, .rst, .output_on, .spinning, .out_current_pct);

	// ========================================
	// compare, wait and pulse helpers
	task automatic chk_bit(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask : chk_val

	// bounded wait, so a stuck state machine shows as one mismatch, not a hang
	task automatic wait_bit(input int sel, input logic val, input int lim);
		logic v;
		for (int i = 0; i < lim; i++) begin
			case (sel)
				0: v = output_on;
				1: v = dc_inject;
				2: v = searching;
				default: v = tripped_off;
			endcase
			if (v === val) return;
			@(negedge clk);
		end
		n_fail++;
		$display("Error at %0t: wait on output %0d timed out", $time, sel);
	endtask : wait_bit

	task automatic pulse(input int k);
		case (k)
			0: ext_block = 1'b1;
			1: fault_reset = 1'b1;
			2: excess_current_trip = 1'b1;
			3: excess_voltage_trip = 1'b1;
			default: ground_leak_trip = 1'b1;
		endcase
		repeat (2) @(negedge clk);
		{ext_block, fault_reset, excess_current_trip, excess_voltage_trip, ground_leak_trip} = 5'h00;
	endtask : pulse

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			wrap_up();
		end
	end

	// ========================================
	// test sequence
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk_bit(output_on, 1'b0);
		chk_val({28'h0, retry_left}, 32'h2);
		run_req = 1'b1;
		wait_bit(1, 1'b1, 10);
		chk_bit(output_on, 1'b1);
		repeat (25) @(negedge clk);
		chk_bit(dc_level >= {1'b0, dc_ramp_rate}, 1'b1);
		// clock enable low must freeze the ramp mid-injection
		ce = 1'b0;
		lvl0 = dc_level;
		repeat (30) @(negedge clk);
		chk_val({15'h0, dc_level}, {15'h0, lvl0});
		ce = 1'b1;
		wait_bit(1, 1'b0, 200);
		chk_bit(out_freq >= dcb_start_freq, 1'b1);
		repeat (300) @(negedge clk);
		chk_val({16'h0, out_freq}, {16'h0, freq_cmd});
		undervoltage_indication = 1'b1;
		repeat (30) @(negedge clk);
		chk_bit(output_on, 1'b1);
		undervoltage_indication = 1'b0;
		for (int s = 1; s < 3; s++) begin
			pwr_restart_sel = s[1:0];
			repeat (5) @(negedge clk);
			chk_bit(output_on, 1'b1);
			undervoltage_indication = 1'b1;
			wait_bit(0, 1'b0, 5);
			repeat (50) @(negedge clk);
			undervoltage_indication = 1'b0;
			repeat (80) @(negedge clk);
			chk_bit(output_on, 1'b0);
			wait_bit(0, 1'b1, 60);
		end
		for (int k = 0; k < 2; k++) begin
			pulse(k);
			wait_bit(0, 1'b0, 5);
			repeat (80) @(negedge clk);
			chk_bit(output_on, 1'b0);
			wait_bit(0, 1'b1, 60);
		end
		spinning = 1'b1;
		pwr_restart_sel = 2'h0;
		for (int t = 0; t < 6; t++) begin
			search_type = t[2:0];
			pulse(0);
			repeat (90) @(negedge clk);
			wait_bit(0, 1'b1, 60);
			chk_bit(searching, t != 0);
			chk_bit(reverse, t == 3 || t == 5);
			chk_bit(auto_dec_inhibit, t != 0);
			f0 = (t == 3 || t == 5) ? search_freq_rev : (t == 1) ? freq_cmd
				: (t == 0) ? freq_min : search_freq_fwd;
			chk_val({16'h0, out_freq}, {16'h0, f0});
			f0 = out_freq;
			@(negedge clk);
			ok = out_volt === {16'h0, f0} * {16'h0, vf_volts_per_hz};
			ok = ok || out_volt === {16'h0, out_freq} * {16'h0, vf_volts_per_hz};
			chk_bit(ok, 1'b1);
			spinning = 1'b0;
			wait_bit(2, 1'b0, 30);
			spinning = 1'b1;
		end
		spinning = 1'b0;
		pwr_restart_sel = 2'h2;
		pulse(0);
		wait_bit(0, 1'b1, 160);
		chk_bit(searching, 1'b0);
		spinning = 1'b1;
		pulse(2);
		repeat (4) @(negedge clk);
		chk_val({28'h0, retry_left}, 32'h1);
		wait_bit(2, 1'b1, 200);
		chk_bit(out_freq > freq_cmd, 1'b1);
		spinning = 1'b0;
		wait_bit(2, 1'b0, 30);
		repeat (600) @(negedge clk);
		chk_val({28'h0, retry_left}, 32'h2);
		pulse(3);
		wait_bit(0, 1'b1, 300);
		pulse(4);
		repeat (4) @(negedge clk);
		chk_val({28'h0, retry_left}, 32'h0);
		wait_bit(0, 1'b1, 300);
		pulse(2);
		repeat (300) @(negedge clk);
		chk_bit(output_on, 1'b0);
		run_req = 1'b0;
		gap_acc_time = 16'h0014;
		repeat (20) @(negedge clk);
		run_req = 1'b1;
		repeat (150) @(negedge clk);
		chk_val({16'h0, out_freq}, {16'h0, gap_acc_freq});
		repeat (400) @(negedge clk);
		undervoltage_indication = 1'b1;
		wait_bit(3, 1'b1, 260);
		chk_bit(output_on, 1'b0);
		wrap_up();
	end
endmodule : motor_restart_speed_search_tb
`default_nettype wire
